/* rtl/flash_cmd_pkg.sv */
package flash_cmd_pkg;

  //////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam logic [7:0] OP_WLATCH_SET = 8'h06;
  localparam logic [7:0] OP_WLATCH_CLR = 8'h04;
  localparam logic [7:0] OP_OTP_ENTER = 8'h3A;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_ID_DEVICE = 8'hAB;
  localparam logic [7:0] OP_ID_MANUF_DEV = 8'h90;
  localparam logic [7:0] OP_ID_FULL = 8'h9F;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;

  //////////////////////////////////////////////////////////////////////////
  // lane widths and phase lengths in bits
  localparam logic [2:0] W_SINGLE = 3'h1;
  localparam logic [2:0] W_DUAL = 3'h2;
  localparam logic [2:0] W_QUAD = 3'h4;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] FAST_DUMMY_BITS = 5'h08;
  localparam logic [4:0] QUAD_DUMMY_BITS = 5'h10;
  localparam logic [4:0] ID_DUMMY_BITS = 5'h18;
  localparam logic [3:0] CONT_MODE_NIBBLE = 4'hA;
  localparam logic [7:0] SH_RESET = 8'h00;
  localparam logic [23:0] ADDR_RESET = 24'h000000;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_MHZ = 100;
  localparam int RECOVERY_ERASE_US = 28;
  localparam int RECOVERY_SHORT_NS = 100;
  localparam logic [11:0] RECOVERY_ERASE_CYC =
    12'(RECOVERY_ERASE_US * CLOCK_MHZ);
  localparam logic [11:0] RECOVERY_SHORT_CYC =
    12'((RECOVERY_SHORT_NS * CLOCK_MHZ) / 1000);

  typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_OUT, ST_SKIP}
    phase_state_t;

  typedef struct packed {
    logic ok;
    logic [4:0] addrBits;
    logic [2:0] addrW;
    logic [4:0] dumBits;
    logic [2:0] dumW;
    logic [2:0] outW;
  } cmd_shape_t;

endpackage

/* rtl/link_if.sv */
`timescale 1ns/100ps
interface link_if;
  logic sckRise;
  logic sckFall;
  logic csActive;
  logic frameStart;
  logic frameEnd;
  logic [3:0] lanes;
  modport src (output sckRise, sckFall, csActive, frameStart, frameEnd,
               lanes);
  modport dst (input sckRise, sckFall, csActive, frameStart, frameEnd,
               lanes);
endinterface

/* rtl/link_sampler.sv */
`timescale 1ns/100ps
module link_sampler
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sckPin,
  input wire logic csPinB,
  input wire logic [3:0] lanePin,
  link_if.src link
);

  // bit 5 serial clock, bit 4 select (low active), bits 3:0 lanes
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sckPrev_r;
  logic csPrevB_r;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      sync1_r <= 6'h10;
      sync2_r <= 6'h10;
      sckPrev_r <= 1'h0;
      csPrevB_r <= 1'h1;
    end
    else
    begin
      sync1_r <= {sckPin, csPinB, lanePin};
      sync2_r <= sync1_r;
      sckPrev_r <= sync2_r[5];
      csPrevB_r <= sync2_r[4];
    end
  end

  // edges decoded from the second stage against its registered previous value, to save a cycle of latency
  assign link.sckRise = sync2_r[5] & ~sckPrev_r & ~sync2_r[4];
  assign link.sckFall = ~sync2_r[5] & sckPrev_r & ~sync2_r[4];
  assign link.csActive = ~sync2_r[4];
  assign link.frameStart = ~sync2_r[4] & csPrevB_r;
  assign link.frameEnd = sync2_r[4] & ~csPrevB_r;
  assign link.lanes = sync2_r[3:0];

endmodule

/* rtl/serial_flash_front.sv */
`timescale 1ns/100ps
// What this block does
// - dual output: odd bits lane1, even lane0
// - quad read: four dummy clocks, nibble data
// - answer three identification opcodes
// - quad enable makes all commands nibble wide
// - no plain/dual reads in quad mode
// - quad exit returns to serial, quad only
// - exit opcode also ends continuous read
// - first exit ends continuous, second quad
// - other command after arm disarms reset
// - reset returns status to all zeros
// - reset aborts running program or erase
// - reset in current width, clears modes
// - reset ignored in deep power-down
// - busy up to 28us after erase reset
// - latch set opcode sets write latch
// - latch clear clears latch and otp mode
// - latch clears on write completion, power-up
// - writes refused while latch is zero
// - MSB first, opcode eight or two clocks
// - execute only right after arm
module serial_flash_front
  import flash_cmd_pkg::*;
#(
  // identity values are arbitrary
  parameter logic [7:0] MANUF_CODE = 8'h5A,
  parameter logic [7:0] DEVICE_CODE = 8'h3C,
  parameter logic [15:0] TYPE_CAP_CODE = 16'h4D21
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sckPin,
  input wire logic csPinB,
  input wire logic [3:0] ioLaneIn,
  input wire logic deepPowerDown,
  input wire logic opBusy,
  input wire logic opEraseActive,
  input wire logic opDone,
  input wire logic [7:0] readData,
  output logic [3:0] ioLaneOut,
  output logic [3:0] ioLaneOe,
  output logic [23:0] memAddr,
  output logic memReadStrobe,
  output logic writeReq,
  output logic [7:0] writeCode,
  output logic opAbort,
  output logic statusToDefault,
  output logic writeEnableLatch,
  output logic writeBusyFlag,
  output logic quadMode,
  output logic contQuadRead,
  output logic otpMode,
  output logic resetArmed
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic cmd_shape_t cmdShape(input logic [7:0] op,
                                          input logic quad);
    cmd_shape_t s;
    logic [2:0] w;
    s = '0;
    w = quad ? W_QUAD : W_SINGLE;
    s.addrW = w;
    s.dumW = w;
    s.outW = w;
    case (op)
      OP_READ:
      begin
        s.ok = !quad;
        s.addrBits = ADDR_BITS;
      end
      OP_FAST_READ:
      begin
        s.ok = 1'h1;
        s.addrBits = ADDR_BITS;
        s.dumBits = FAST_DUMMY_BITS;
      end
      OP_DUAL_OUT_READ:
      begin
        s.ok = !quad;
        s.addrBits = ADDR_BITS;
        s.dumBits = FAST_DUMMY_BITS;
        s.outW = W_DUAL;
      end
      OP_DUAL_IO_READ:
      begin
        s.ok = !quad;
        s.addrBits = ADDR_BITS;
        s.addrW = W_DUAL;
        s.dumBits = FAST_DUMMY_BITS;
        s.dumW = W_DUAL;
        s.outW = W_DUAL;
      end
      // sixteen dummy bits on four lanes
      OP_QUAD_IO_READ:
      begin
        s.ok = 1'h1;
        s.addrBits = ADDR_BITS;
        s.addrW = W_QUAD;
        s.dumBits = QUAD_DUMMY_BITS;
        s.dumW = W_QUAD;
        s.outW = W_QUAD;
      end
      OP_ID_DEVICE:
      begin
        s.ok = 1'h1;
        s.dumBits = ID_DUMMY_BITS;
      end
      OP_ID_MANUF_DEV:
      begin
        s.ok = 1'h1;
        s.addrBits = ADDR_BITS;
      end
      OP_ID_FULL:
        s.ok = 1'h1;
      default:
        s.ok = 1'h0;
    endcase
    return s;
  endfunction

  function automatic logic [3:0] lanePick(input logic [3:0] l,
                                          input logic [2:0] w);
    case (w)
      W_QUAD: return l;
      W_DUAL: return {2'h0, l[1:0]};
      default: return {3'h0, l[0]};
    endcase
  endfunction

  // dual: odd bit lane 1, even bit lane 0; single: every bit on lane 1
  function automatic logic [3:0] laneDrive(input logic [7:0] b,
                                           input logic [2:0] w);
    case (w)
      W_QUAD: return b[7:4];
      W_DUAL: return {2'h0, b[7:6]};
      default: return {2'h0, b[7], 1'h0};
    endcase
  endfunction

  function automatic logic [3:0] laneMask(input logic [2:0] w);
    case (w)
      W_QUAD: return 4'hF;
      W_DUAL: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction

  function automatic logic isWriteOp(input logic [7:0] op);
    return op == OP_STATUS_WRITE || op == OP_PAGE_PROGRAM ||
           op == OP_SECTOR_ERASE || op == OP_BLOCK_ERASE ||
           op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link sampling

  link_if link ();

  link_sampler u_sampler (
    .clock(clock),
    .rst_b(rst_b),
    .sckPin(sckPin),
    .csPinB(csPinB),
    .lanePin(ioLaneIn),
    .link(link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and decode

  phase_state_t state_r;
  cmd_shape_t shape_r;
  logic [4:0] bitCnt_r;
  logic [7:0] sh_r;
  logic [7:0] opcode_r;
  logic [7:0] modeByte_r;
  logic [23:0] addr_r;
  logic opcDone_r;
  logic contFrame_r;
  logic extra_r;
  logic [3:0] ioLaneOut_r;
  logic [3:0] ioLaneOe_r;
  logic [23:0] memAddr_r;
  logic memReadStrobe_r;
  logic [7:0] outSh_r;
  logic [3:0] outCnt_r;
  logic [1:0] byteIdx_r;
  logic writeReq_r;
  logic [7:0] writeCode_r;
  logic opAbort_r;
  logic statusToDefault_r;
  logic writeEnableLatch_r;
  logic writeBusyFlag_r;
  logic quadMode_r;
  logic contQuadRead_r;
  logic otpMode_r;
  logic resetArm_r;
  logic [11:0] recCnt_r;

  logic [2:0] phaseW;
  logic [4:0] bitNext;
  logic [7:0] shNext;
  logic [23:0] addrNext;
  cmd_shape_t newShape;
  phase_state_t afterOpc;
  logic addrDone;
  logic contDecide;
  logic contShort;
  logic endCmd;
  logic endOnly;
  logic [7:0] endOp;
  logic [7:0] nextByte;
  logic isArray;

  always_comb
  begin
    case (state_r)
      ST_ADDR: phaseW = shape_r.addrW;
      ST_DUMMY: phaseW = shape_r.dumW;
      default: phaseW = quadMode_r ? W_QUAD : W_SINGLE;
    endcase
  end

  assign bitNext = 5'(bitCnt_r + {2'h0, phaseW});
  assign shNext = 8'((sh_r << phaseW) | {4'h0, lanePick(link.lanes, phaseW)});
  assign addrNext = 24'((addr_r << phaseW) |
                        {20'h0, lanePick(link.lanes, phaseW)});
  assign newShape = cmdShape(shNext, quadMode_r);
  assign addrDone = link.sckRise && state_r == ST_ADDR &&
                    bitNext == shape_r.addrBits;
  assign contDecide = link.sckRise && state_r == ST_DUMMY &&
                      bitNext == shape_r.dumBits &&
                      opcode_r == OP_QUAD_IO_READ;

  always_comb
  begin
    if (!newShape.ok)
      afterOpc = ST_SKIP;
    else if (newShape.addrBits != 5'h00)
      afterOpc = ST_ADDR;
    else if (newShape.dumBits != 5'h00)
      afterOpc = ST_DUMMY;
    else
      afterOpc = ST_OUT;
  end

  // a lone byte in a continuous frame is a command
  assign contShort = contFrame_r && state_r == ST_ADDR &&
                     bitCnt_r == BYTE_BITS;
  assign endOp = contShort ? addr_r[7:0] : opcode_r;
  assign endOnly = contShort || (state_r == ST_SKIP && !extra_r);
  assign endCmd = link.frameEnd && (opcDone_r || contFrame_r);

  logic execSet;
  logic execClr;
  logic execQuadEnter;
  logic execQuadExit;
  logic execOtp;
  logic rstExec;
  assign execSet = endCmd && endOnly && endOp == OP_WLATCH_SET;
  assign execClr = endCmd && endOnly && endOp == OP_WLATCH_CLR;
  assign execQuadEnter = endCmd && endOnly && endOp == OP_QUAD_ENTER;
  assign execQuadExit = endCmd && endOnly && endOp == OP_QUAD_EXIT;
  assign execOtp = endCmd && endOnly && endOp == OP_OTP_ENTER;
  // only right after arm, not in power-down
  assign rstExec = endCmd && endOnly && endOp == OP_RESET_EXEC &&
                   resetArm_r && !deepPowerDown;

  ////////////////////////////////////////////////////////////////////////////
  // phase machine

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      shape_r <= '0;
      bitCnt_r <= 5'h00;
      sh_r <= SH_RESET;
      opcode_r <= SH_RESET;
      modeByte_r <= SH_RESET;
      addr_r <= ADDR_RESET;
      opcDone_r <= 1'h0;
      contFrame_r <= 1'h0;
      extra_r <= 1'h0;
    end
    else if (link.frameEnd)
      state_r <= ST_IDLE;
    else if (link.frameStart)
    begin
      bitCnt_r <= 5'h00;
      sh_r <= SH_RESET;
      opcDone_r <= 1'h0;
      extra_r <= 1'h0;
      contFrame_r <= contQuadRead_r;
      if (contQuadRead_r)
      begin
        state_r <= ST_ADDR;
        opcode_r <= OP_QUAD_IO_READ;
        shape_r <= cmdShape(OP_QUAD_IO_READ, quadMode_r);
      end
      else
        state_r <= ST_OPC;
    end
    else if (link.sckRise)
    begin
      case (state_r)
        ST_OPC:
        begin
          sh_r <= shNext;
          bitCnt_r <= bitNext;
          if (bitNext == BYTE_BITS)
          begin
            opcode_r <= shNext;
            shape_r <= newShape;
            opcDone_r <= 1'h1;
            bitCnt_r <= 5'h00;
            state_r <= afterOpc;
          end
        end
        ST_ADDR:
        begin
          addr_r <= addrNext;
          bitCnt_r <= bitNext;
          if (bitNext == shape_r.addrBits)
          begin
            bitCnt_r <= 5'h00;
            state_r <= shape_r.dumBits != 5'h00 ? ST_DUMMY : ST_OUT;
          end
        end
        ST_DUMMY:
        begin
          sh_r <= shNext;
          bitCnt_r <= bitNext;
          if (bitNext == BYTE_BITS)
            modeByte_r <= shNext;
          if (bitNext == shape_r.dumBits)
          begin
            bitCnt_r <= 5'h00;
            state_r <= ST_OUT;
          end
        end
        ST_SKIP:
          extra_r <= 1'h1;
        default:
          state_r <= state_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive

  always_comb
  begin
    isArray = 1'h0;
    case (opcode_r)
      OP_ID_DEVICE: nextByte = DEVICE_CODE;
      OP_ID_MANUF_DEV:
        nextByte = (byteIdx_r[0] ^ memAddr_r[0]) ? DEVICE_CODE : MANUF_CODE;
      OP_ID_FULL:
        case (byteIdx_r)
          2'h0: nextByte = MANUF_CODE;
          2'h1: nextByte = TYPE_CAP_CODE[15:8];
          default: nextByte = TYPE_CAP_CODE[7:0];
        endcase
      default:
      begin
        nextByte = readData;
        isArray = 1'h1;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ioLaneOut_r <= 4'h0;
      ioLaneOe_r <= 4'h0;
      outSh_r <= SH_RESET;
      outCnt_r <= 4'h0;
      byteIdx_r <= 2'h0;
      memReadStrobe_r <= 1'h0;
      memAddr_r <= ADDR_RESET;
    end
    else
    begin
      memReadStrobe_r <= 1'h0;
      if (link.frameEnd || state_r == ST_IDLE)
      begin
        ioLaneOe_r <= 4'h0;
        outCnt_r <= 4'h0;
        byteIdx_r <= 2'h0;
      end
      else if (addrDone)
        memAddr_r <= addrNext;
      else if (state_r == ST_OUT && link.sckFall)
      begin
        if (outCnt_r == 4'h0)
        begin
          ioLaneOut_r <= laneDrive(nextByte, shape_r.outW);
          ioLaneOe_r <= laneMask(shape_r.outW);
          outSh_r <= 8'(nextByte << shape_r.outW);
          outCnt_r <= 4'(4'h8 - {1'h0, shape_r.outW});
          byteIdx_r <= (opcode_r == OP_ID_FULL && byteIdx_r == 2'h2) ?
                       2'h0 : 2'(byteIdx_r + 2'h1);
          if (isArray)
          begin
            memReadStrobe_r <= 1'h1;
            memAddr_r <= 24'(memAddr_r + 24'h000001);
          end
        end
        else
        begin
          ioLaneOut_r <= laneDrive(outSh_r, shape_r.outW);
          outSh_r <= 8'(outSh_r << shape_r.outW);
          outCnt_r <= 4'(outCnt_r - {1'h0, shape_r.outW});
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interface modes

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      quadMode_r <= 1'h0;
      contQuadRead_r <= 1'h0;
    end
    // reset clears quad and continuous modes
    else if (rstExec)
    begin
      quadMode_r <= 1'h0;
      contQuadRead_r <= 1'h0;
    end
    else
    begin
      if (execQuadEnter && !quadMode_r)
        quadMode_r <= 1'h1;
      if (execQuadExit)
      begin
        if (contQuadRead_r)
          contQuadRead_r <= 1'h0;
        else
          quadMode_r <= 1'h0;
      end
      if (contDecide)
        contQuadRead_r <= modeByte_r[7:4] == CONT_MODE_NIBBLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software reset

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      resetArm_r <= 1'h0;
    else if (endCmd)
      resetArm_r <= endOnly && endOp == OP_RESET_ARM;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      recCnt_r <= 12'h000;
      opAbort_r <= 1'h0;
      statusToDefault_r <= 1'h0;
      writeBusyFlag_r <= 1'h0;
    end
    else
    begin
      opAbort_r <= rstExec && opBusy;
      statusToDefault_r <= rstExec;
      if (rstExec)
        recCnt_r <= opEraseActive ? RECOVERY_ERASE_CYC : RECOVERY_SHORT_CYC;
      else if (recCnt_r != 12'h000)
        recCnt_r <= 12'(recCnt_r - 12'h001);
      writeBusyFlag_r <= opBusy || rstExec || recCnt_r > 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write enable latch

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      writeEnableLatch_r <= 1'h0;
      otpMode_r <= 1'h0;
    end
    else
    begin
      // cleared by completion, clear command, reset
      if (opDone || execClr || rstExec)
        writeEnableLatch_r <= 1'h0;
      // set wins over a same-cycle clear
      if (execSet)
        writeEnableLatch_r <= 1'h1;
      if (execClr || rstExec)
        otpMode_r <= 1'h0;
      else if (execOtp)
        otpMode_r <= 1'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      writeReq_r <= 1'h0;
      writeCode_r <= SH_RESET;
    end
    else
    begin
      writeReq_r <= endCmd && opcDone_r && isWriteOp(opcode_r) &&
                    writeEnableLatch_r;
      if (endCmd && opcDone_r)
        writeCode_r <= opcode_r;
    end
  end

  assign ioLaneOut = ioLaneOut_r;
  assign ioLaneOe = ioLaneOe_r;
  assign memAddr = memAddr_r;
  assign memReadStrobe = memReadStrobe_r;
  assign writeReq = writeReq_r;
  assign writeCode = writeCode_r;
  assign opAbort = opAbort_r;
  assign statusToDefault = statusToDefault_r;
  assign writeEnableLatch = writeEnableLatch_r;
  assign writeBusyFlag = writeBusyFlag_r;
  assign quadMode = quadMode_r;
  assign contQuadRead = contQuadRead_r;
  assign otpMode = otpMode_r;
  assign resetArmed = resetArm_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_WEL_SET: assert property (
    @(posedge clock) disable iff (!rst_b)
    execSet |=> writeEnableLatch_r [*2])
    else $error("latch not set by set command");

  AST_WEL_CLR: assert property (
    @(posedge clock) disable iff (!rst_b)
    execClr && !execSet |=> !writeEnableLatch_r && !otpMode_r)
    else $error("latch or otp mode not cleared");

  AST_WEL_DONE: assert property (
    @(posedge clock) disable iff (!rst_b)
    opDone && !execSet |=> !writeEnableLatch_r)
    else $error("latch survived completion");

  AST_WRITE_GATE: assert property (
    @(posedge clock) disable iff (!rst_b)
    writeReq_r |-> $past(writeEnableLatch_r))
    else $error("write issued with latch clear");

  AST_QUAD_ENTER: assert property (
    @(posedge clock) disable iff (!rst_b)
    execQuadEnter && !rstExec |=> quadMode_r)
    else $error("quad mode not entered");

  AST_DISARM: assert property (
    @(posedge clock) disable iff (!rst_b)
    endCmd && !(endOnly && endOp == OP_RESET_ARM) |=> !resetArm_r)
    else $error("reset arm kept after other command");

  AST_RESET_EFFECT: assert property (
    @(posedge clock) disable iff (!rst_b)
    rstExec |=> statusToDefault_r && !quadMode_r && !contQuadRead_r
               && !writeEnableLatch_r)
    else $error("reset did not clear modes");

  AST_DPD_IGNORE: assert property (
    @(posedge clock) disable iff (!rst_b)
    endCmd && deepPowerDown |=> !statusToDefault_r)
    else $error("reset acted in power-down");

  AST_RECOVERY: assert property (
    @(posedge clock) disable iff (!rst_b)
    rstExec && opEraseActive |=> writeBusyFlag_r [*8])
    else $error("busy dropped during recovery");

  AST_QUAD_OPC: assert property (
    @(posedge clock) disable iff (!rst_b)
    state_r == ST_OPC && quadMode_r && link.sckRise && bitCnt_r == 5'h04
    && !link.frameEnd |=> state_r != ST_OPC && opcDone_r)
    else $error("quad opcode not two clocks");

endmodule

/* testbench/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model
(
  input wire logic clock,
  output logic sckPin,
  output logic csPinB,
  output logic [3:0] lanes,
  input wire logic [3:0] laneWire
);
  logic [3:0] s;
  initial
  begin
    sckPin = 1'b0;
    csPinB = 1'b1;
    lanes = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////////
  // one sck pulse, 80 ns period
  task automatic pulse(input logic [3:0] v);
    lanes <= v;
    repeat (4) @(posedge clock);
    sckPin <= 1'b1;
    repeat (4) @(posedge clock);
    s = laneWire;
    sckPin <= 1'b0;
  endtask
  // msb first, 8 or 2 clocks
  task automatic xfer(input logic [7:0] d, input logic q,
                      output logic [7:0] r);
    if (q)
    begin
      pulse(d[7:4]);
      r[7:4] = s;
      pulse(d[3:0]);
      r[3:0] = s;
    end
    else
    begin
      for (int i = 7; i >= 0; i--)
      begin
        pulse({3'h7, d[i]});
        r[i] = s[1];
      end
    end
  endtask
  // dual: odd bit lane 1, even bit lane 0
  task automatic xfer2(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i > 0; i -= 2)
    begin
      pulse({2'h3, d[i -: 2]});
      r[i -: 2] = s[1:0];
    end
  endtask
  task automatic open;
    csPinB <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic close;
    repeat (4) @(posedge clock);
    csPinB <= 1'b1;
    lanes <= 4'hF;
    repeat (12) @(posedge clock);
  endtask
  task automatic cmd(input logic [7:0] op, input logic q);
    logic [7:0] r;
    open();
    xfer(op, q, r);
    close();
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) \
  compares++; \
  if ((a) !== (e)) \
  begin \
    $display("ERROR %s exp %h got %h", n, e, a); \
    numErrors++; \
  end
module testbench
  import flash_cmd_pkg::*;
;
  localparam logic [7:0] MANUF = 8'h5A;
  localparam logic [7:0] DEV = 8'h3C;
  localparam logic [15:0] TCAP = 16'h4D21;
  logic clock, rst_b, sck, csB, dpd, busy, done;
  logic [3:0] hostLanes, laneWire, lOut, lOe;
  logic write_enable_latch, quad, cont, armed, toDef, abort;
  logic erase, wbusy, wreq, otp;
  logic [7:0] r, r2, wcode;
  logic [23:0] mAddr;
  int numErrors, compares, resets, aborts, cyc, writes;
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign laneWire[i] = lOe[i] ? lOut[i] : hostLanes[i];
  end
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  serial_flash_front #(.MANUF_CODE(MANUF), .DEVICE_CODE(DEV),
    .TYPE_CAP_CODE(TCAP)) dut_u (.clock(clock), .rst_b(rst_b),
    .sckPin(sck), .csPinB(csB), .ioLaneIn(laneWire),
    .deepPowerDown(dpd), .opBusy(busy), .opEraseActive(erase),
    .opDone(done), .readData(mAddr[7:0]), .ioLaneOut(lOut),
    .ioLaneOe(lOe), .memAddr(mAddr), .memReadStrobe(),
    .writeReq(wreq), .writeCode(wcode),
    .opAbort(abort), .statusToDefault(toDef), .writeEnableLatch(write_enable_latch),
    .writeBusyFlag(wbusy), .quadMode(quad), .contQuadRead(cont),
    .otpMode(otp), .resetArmed(armed));
  spi_host_model host_u (.clock(clock), .sckPin(sck), .csPinB(csB),
    .lanes(hostLanes), .laneWire(laneWire));
  always @(posedge clock)
  begin
    cyc++;
    if (toDef === 1'b1) resets++;
    if (abort === 1'b1) aborts++;
    if (wreq === 1'b1) writes++;
    if (cyc > 20000)
    begin
      numErrors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic swReset(input logic q);
    host_u.cmd(OP_RESET_ARM, q);
    host_u.cmd(OP_RESET_EXEC, q);
  endtask
  initial
  begin
    rst_b = 1'b0;
    {dpd, busy, done, erase} = 4'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("modes", 4'h0, {write_enable_latch, quad, cont, armed})
    host_u.cmd(OP_WLATCH_SET, 1'b0);
    `CHK("latch set", 1'b1, write_enable_latch)
    done <= 1'b1;
    @(posedge clock);
    done <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("latch done", 1'b0, write_enable_latch)
    host_u.cmd(OP_OTP_ENTER, 1'b0);
    host_u.cmd(OP_WLATCH_SET, 1'b0);
    `CHK("otp on", 2'h3, {write_enable_latch, otp})
    host_u.cmd(OP_WLATCH_CLR, 1'b0);
    `CHK("latch clr", 2'h0, {write_enable_latch, otp})
    host_u.cmd(OP_PAGE_PROGRAM, 1'b0);
    `CHK("write refused", 0, writes)
    host_u.cmd(OP_WLATCH_SET, 1'b0);
    host_u.cmd(OP_PAGE_PROGRAM, 1'b0);
    `CHK("write taken", 1, writes)
    `CHK("write code", OP_PAGE_PROGRAM, wcode)
    $display("latch test done");
    host_u.cmd(OP_RESET_ARM, 1'b0);
    `CHK("armed", 1'b1, armed)
    host_u.cmd(OP_WLATCH_SET, 1'b0);
    `CHK("disarm", 1'b0, armed)
    host_u.cmd(OP_RESET_EXEC, 1'b0);
    `CHK("no reset", 0, resets)
    busy <= 1'b1;
    swReset(1'b0);
    busy <= 1'b0;
    `CHK("reset", 1, resets)
    `CHK("abort", 1, aborts)
    `CHK("reset latch", 1'b0, write_enable_latch)
    dpd <= 1'b1;
    swReset(1'b0);
    dpd <= 1'b0;
    `CHK("dpd reset", 1, resets)
    $display("reset test done");
    host_u.cmd(OP_QUAD_EXIT, 1'b0);
    `CHK("exit serial", 1'b0, quad)
    host_u.cmd(OP_QUAD_ENTER, 1'b0);
    `CHK("quad on", 1'b1, quad)
    host_u.cmd(OP_WLATCH_SET, 1'b1);
    `CHK("quad latch", 1'b1, write_enable_latch)
    host_u.cmd(OP_QUAD_EXIT, 1'b1);
    `CHK("quad off", 1'b0, quad)
    host_u.cmd(OP_QUAD_ENTER, 1'b0);
    swReset(1'b1);
    `CHK("quad reset", 2'h0, {quad, write_enable_latch})
    `CHK("quad reset n", 2, resets)
    $display("quad test done");
    host_u.cmd(OP_QUAD_ENTER, 1'b0);
    host_u.open();
    host_u.xfer(OP_QUAD_IO_READ, 1'b1, r);
    host_u.xfer(8'h12, 1'b1, r);
    host_u.xfer(8'h34, 1'b1, r);
    host_u.xfer(8'h56, 1'b1, r);
    host_u.xfer({CONT_MODE_NIBBLE, 4'h0}, 1'b1, r);
    host_u.xfer(8'h00, 1'b1, r);
    host_u.xfer(8'h00, 1'b1, r);
    host_u.xfer(8'h00, 1'b1, r2);
    `CHK("oe quad", 4'hF, lOe)
    host_u.close();
    `CHK("quad data", 16'h5657, {r, r2})
    `CHK("cont on", 2'h3, {quad, cont})
    host_u.cmd(OP_QUAD_EXIT, 1'b1);
    `CHK("cont off", 2'h2, {quad, cont})
    host_u.cmd(OP_QUAD_EXIT, 1'b1);
    `CHK("quad off 2", 2'h0, {quad, cont})
    host_u.open();
    host_u.xfer(OP_DUAL_IO_READ, 1'b0, r);
    host_u.xfer2(8'h12, r);
    host_u.xfer2(8'h34, r);
    host_u.xfer2(8'h58, r);
    host_u.xfer2(8'h00, r);
    host_u.xfer2(8'h00, r);
    `CHK("oe dual", 4'h3, lOe)
    host_u.close();
    `CHK("dual data", 8'h58, r)
    $display("read test done");
    busy <= 1'b1;
    erase <= 1'b1;
    swReset(1'b1);
    swReset(1'b0);
    busy <= 1'b0;
    erase <= 1'b0;
    repeat (100) @(posedge clock);
    `CHK("recovery", 1'b1, wbusy)
    repeat (RECOVERY_ERASE_CYC) @(posedge clock);
    `CHK("recovered", 1'b0, wbusy)
    `CHK("reset n3", 3, resets)
    `CHK("abort 2", 2, aborts)
    $display("recovery test done");
    host_u.open();
    host_u.xfer(OP_ID_DEVICE, 1'b0, r);
    repeat (3) host_u.xfer(8'h00, 1'b0, r);
    host_u.xfer(8'h00, 1'b0, r);
    `CHK("oe id", 4'h2, lOe)
    host_u.close();
    `CHK("dev id", DEV, r)
    host_u.open();
    host_u.xfer(OP_ID_FULL, 1'b0, r);
    host_u.xfer(8'h00, 1'b0, r);
    host_u.xfer(8'h00, 1'b0, r2);
    `CHK("manuf", MANUF, r)
    `CHK("type", TCAP[15:8], r2)
    host_u.xfer(8'h00, 1'b0, r);
    host_u.close();
    `CHK("cap", TCAP[7:0], r)
    $display("id test done");
    final_report();
  end
endmodule
